// [utxdr_pkg.sv]
package utxdr_pkg;
   // transmit queue geometry
   localparam int          UTXDR_DEPTH     = 64;
   localparam logic [6:0]  UTXDR_FULL_LVL  = 7'h40;
   localparam logic [6:0]  UTXDR_SUM_LIMIT = 7'h3f;

   // register offsets on the configuration port
   localparam logic [7:0]  OFS_PORTAL8     = 8'h08;
   localparam logic [7:0]  OFS_LCR_PORTAL  = 8'h0c;
   localparam logic [7:0]  OFS_MODEM       = 8'h10;
   localparam logic [7:0]  OFS_TRIG_SEL    = 8'h1c;
   localparam logic [7:0]  OFS_SUPP        = 8'h40;
   localparam logic [7:0]  OFS_MODE3       = 8'h80;
   localparam logic [7:0]  OFS_TXREQ_LVL   = 8'h84;
   localparam logic [7:0]  OFS_STATUS      = 8'h88;
   localparam logic [7:0]  OFS_MASK        = 8'h8c;
   localparam logic [7:0]  OFS_LEVEL       = 8'h90;

   // reset values and portal keys
   localparam logic [7:0]  REG_RST         = 8'h00;
   localparam logic [7:0]  PORTAL_KEY_EFR  = 8'hbf;
   localparam logic [7:0]  PORTAL_KEY_FCR  = 8'h00;

   // field positions
   localparam int          EFR_ENH_BIT     = 4;
   localparam int          SCR_FINE_BIT    = 6;
   localparam int          MCR_TLR_BIT     = 6;
   localparam int          MODE_DEFINITION_THREE_THR_BIT    = 2;
   localparam int          FCR_DMA_BIT     = 3;
   localparam int          FCR_TRIG_LSB    = 4;
   localparam int          COARSE_SHIFT    = 2;
   localparam int          ST_SYNC_BIT     = 0;
   localparam int          ST_OVF_BIT      = 1;
   localparam int          ST_CROSS_BIT    = 2;
   localparam logic [5:0]  DEFAULT_BURST   = 6'h08;

   // controller's own registers on its user port
   localparam logic [3:0]  HOFS_CTRL       = 4'h0;
   localparam logic [3:0]  HOFS_TRIG       = 4'h4;
   localparam logic [3:0]  HOFS_THR        = 4'h8;
   localparam logic [3:0]  HOFS_STAT       = 4'hc;
   localparam logic [3:0]  HOFS_PEEK       = 4'h1;
   localparam logic [3:0]  HOFS_PEEKD      = 4'h2;
   localparam logic [3:0]  CFG_LAST_STEP   = 4'h8;

   typedef enum logic [3:0] {
      UTXDR_S_IDLE  = 4'b0001,
      UTXDR_S_CFG   = 4'b0010,
      UTXDR_S_RUN   = 4'b0100,
      UTXDR_S_BURST = 4'b1000
   } utxdr_state_t;
endpackage

// [utxdr_if.sv]
`timescale 1ns/1ps
interface utxdr_if;
   // configuration access
   logic [7:0] cfg_addr;
   logic [7:0] cfg_wdata;
   logic       cfg_wr;
   logic       cfg_rd;
   logic [7:0] cfg_rdata;
   // transfer request and refill
   logic       serial_transmit_transfer_request;
   logic [5:0] dma_len;
   logic       dma_wr;
   logic [7:0] dma_wdata;

   modport dev (
      input  cfg_addr, cfg_wdata, cfg_wr, cfg_rd, dma_wr, dma_wdata,
      output cfg_rdata, serial_transmit_transfer_request, dma_len
   );
   modport dma (
      output cfg_addr, cfg_wdata, cfg_wr, cfg_rd, dma_wr, dma_wdata,
      input  cfg_rdata, serial_transmit_transfer_request, dma_len
   );
endinterface

// [utxdr_dev.sv]
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module utxdr_dev
   import utxdr_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // link to the transfer controller
   utxdr_if.dev            lnk,
   // serialiser side
   output logic [7:0]      tx_data,
   output logic            tx_valid,
   input  wire logic       tx_ready,
   // status
   output logic            tx_queue_full,
   output logic            irq
);

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [7:0] efr_ff, lcr_ff, mcr_ff, tlr_ff, spr_ff, scr_ff, mode_definition_three_ff, thr_ff;
   logic [7:0] fcr_ff, mask_ff, status_ff, rdata_ff;
   logic [7:0] nxt_status;

   // portal decode: offset 8 is the feature register only behind the key
   wire efr_sel  = (lcr_ff == PORTAL_KEY_EFR);
   wire fcr_sel  = !efr_sel;
   wire enh_on   = efr_ff[EFR_ENH_BIT];
   wire tlr_open = enh_on && mcr_ff[MCR_TLR_BIT];
   wire wr       = lnk.cfg_wr;
   wire at8      = (lnk.cfg_addr == OFS_PORTAL8);
   wire we_efr   = wr && at8 && efr_sel;
   wire we_fcr   = wr && at8 && fcr_sel;
   wire we_lcr   = wr && (lnk.cfg_addr == OFS_LCR_PORTAL);
   wire we_mcr   = wr && (lnk.cfg_addr == OFS_MODEM) && enh_on;
   wire we_tsel  = wr && (lnk.cfg_addr == OFS_TRIG_SEL);
   wire we_tlr   = we_tsel && tlr_open;
   wire we_spr   = we_tsel && !tlr_open;
   wire we_scr   = wr && (lnk.cfg_addr == OFS_SUPP);
   wire we_mode_definition_three  = wr && (lnk.cfg_addr == OFS_MODE3);
   wire we_thr   = wr && (lnk.cfg_addr == OFS_TXREQ_LVL);
   wire we_stat  = wr && (lnk.cfg_addr == OFS_STATUS);
   wire we_mask  = wr && (lnk.cfg_addr == OFS_MASK);

   // plain storage registers, each loads its own write strobe
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         efr_ff  <= REG_RST;
         lcr_ff  <= REG_RST;
         mcr_ff  <= REG_RST;
         tlr_ff  <= REG_RST;
         spr_ff  <= REG_RST;
         scr_ff  <= REG_RST;
         mode_definition_three_ff <= REG_RST;
         thr_ff  <= REG_RST;
         fcr_ff  <= REG_RST;
         mask_ff <= REG_RST;
      end else begin
         if (we_efr)  efr_ff  <= lnk.cfg_wdata;
         if (we_lcr)  lcr_ff  <= lnk.cfg_wdata;
         if (we_mcr)  mcr_ff  <= lnk.cfg_wdata;
         if (we_tlr)  tlr_ff  <= lnk.cfg_wdata;
         if (we_spr)  spr_ff  <= lnk.cfg_wdata;
         if (we_scr)  scr_ff  <= lnk.cfg_wdata;
         if (we_mode_definition_three) mode_definition_three_ff <= lnk.cfg_wdata;
         if (we_thr)  thr_ff  <= lnk.cfg_wdata;
         if (we_fcr)  fcr_ff  <= lnk.cfg_wdata;
         if (we_mask) mask_ff <= lnk.cfg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit queue
   logic [7:0] mem [UTXDR_DEPTH];
   logic [5:0] wr_ptr_ff, rd_ptr_ff;
   logic [6:0] count_ff;
   logic       full_ff, full_meta_ff, full_sync_ff;
   logic [7:0] out_data_ff;
   logic       out_valid_ff;

   wire full_now = (count_ff == UTXDR_FULL_LVL);
   wire empty    = (count_ff == 7'h00);
   wire push     = lnk.dma_wr && !full_now;
   wire pop      = !empty && (!out_valid_ff || tx_ready);
   wire overflow = lnk.dma_wr && full_now;
   wire [6:0] nxt_count = count_ff + {6'h00, push} - {6'h00, pop};

   // storage array, no reset needed on data
   always_ff @(posedge clock) begin
      if (push) mem[wr_ptr_ff] <= lnk.dma_wdata;
   end

   // pointers, level and output stage
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_ff    <= 6'h00;
         rd_ptr_ff    <= 6'h00;
         count_ff     <= 7'h00;
         out_data_ff  <= REG_RST;
         out_valid_ff <= 1'b0;
      end else begin
         if (push) wr_ptr_ff <= wr_ptr_ff + 6'h01;
         if (pop) begin
            rd_ptr_ff   <= rd_ptr_ff + 6'h01;
            out_data_ff <= mem[rd_ptr_ff];
         end
         if (pop) out_valid_ff <= 1'b1;
         else if (tx_ready) out_valid_ff <= 1'b0;
         count_ff <= nxt_count;
      end
   end

   // full flag is registered, then treated as foreign to the request logic
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         full_ff      <= 1'b0;
         full_meta_ff <= 1'b0;
         full_sync_ff <= 1'b0;
      end else begin
         full_ff      <= (nxt_count == UTXDR_FULL_LVL);
         full_meta_ff <= full_ff;
         full_sync_ff <= full_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger level and request generation
   wire        fine     = scr_ff[SCR_FINE_BIT];
   wire [1:0]  fcr_trig = fcr_ff[FCR_TRIG_LSB +: 2];
   wire [6:0]  trig_fine   = {1'b0, tlr_ff[3:0], fcr_trig};
   wire [6:0]  trig_coarse = {1'b0, tlr_ff[3:0], 2'b00};
   wire [6:0]  trig_lvl = fine ? trig_fine : trig_coarse;
   wire        thr_on   = mode_definition_three_ff[MODE_DEFINITION_THREE_THR_BIT];
   wire [5:0]  burst    = thr_on ? thr_ff[5:0] : DEFAULT_BURST;
   wire        dma_on   = fcr_ff[FCR_DMA_BIT];
   wire        below    = dma_on && (count_ff <= trig_lvl);
   logic       below_ff, req_ff;
   logic [5:0] len_ff;
   // a crossing is the first cycle at or under the level, so one pulse each
   wire        crossing = below && !below_ff;
   // a request raised while the queue reads full is surplus, not data demand
   wire        surplus  = crossing && full_sync_ff;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         below_ff <= 1'b0;
         req_ff   <= 1'b0;
         len_ff   <= 6'h00;
      end else begin
         below_ff <= below;
         req_ff   <= crossing && !full_sync_ff;
         if (crossing) len_ff <= burst;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky status; a new event wins over a write-one clear
   wire [7:0] events = (8'h01 << ST_SYNC_BIT) & {8{surplus}}
                     | (8'h01 << ST_OVF_BIT)  & {8{overflow}}
                     | (8'h01 << ST_CROSS_BIT) & {8{crossing}};
   wire [7:0] clr    = we_stat ? lnk.cfg_wdata : 8'h00;
   assign nxt_status = (status_ff & ~clr) | events;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) status_ff <= REG_RST;
      else status_ff <= nxt_status;
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux, data stands the cycle after the strobe
   logic [7:0] rmux;
   always_comb begin
      unique case (lnk.cfg_addr)
         OFS_PORTAL8:    rmux = efr_sel ? efr_ff : fcr_ff;
         OFS_LCR_PORTAL: rmux = lcr_ff;
         OFS_MODEM:      rmux = mcr_ff;
         OFS_TRIG_SEL:   rmux = tlr_open ? tlr_ff : spr_ff;
         OFS_SUPP:       rmux = scr_ff;
         OFS_MODE3:      rmux = mode_definition_three_ff;
         OFS_TXREQ_LVL:  rmux = thr_ff;
         OFS_STATUS:     rmux = status_ff;
         OFS_MASK:       rmux = mask_ff;
         OFS_LEVEL:      rmux = {1'b0, count_ff};
         default:        rmux = 8'h00;  // unmapped offsets read zero
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) rdata_ff <= REG_RST;
      else if (lnk.cfg_rd) rdata_ff <= rmux;
      else rdata_ff <= 8'h00;
   end

   // outputs
   assign lnk.cfg_rdata = rdata_ff;
   assign lnk.serial_transmit_transfer_request = req_ff;
   assign lnk.dma_len   = len_ff;
   assign tx_data       = out_data_ff;
   assign tx_valid      = out_valid_ff;
   assign tx_queue_full = full_ff;
   assign irq           = |(status_ff & mask_ff);
endmodule

// [utxdr_dma.sv]
`timescale 1ns/1ps
module utxdr_dma
   import utxdr_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // link to the serial port
   utxdr_if.dma            lnk,
   // software port
   input  wire logic [3:0] usr_addr,
   input  wire logic [7:0] usr_wdata,
   input  wire logic       usr_wr,
   input  wire logic       usr_rd,
   output logic [7:0]      usr_rdata,
   // byte source
   input  wire logic [7:0] src_data,
   input  wire logic       src_valid,
   output logic            src_ready
);

   ////////////////////////////////////////////////////////////////////////
   utxdr_state_t state_ff, nxt_state;
   logic [5:0] trig_ff, thr_ff, left_ff;
   logic [3:0] step_ff;
   logic       pend_ff, refused_ff, done_ff, peek_go_ff, peek_cap_ff;
   logic [7:0] peek_addr_ff, peek_data_ff, rdata_ff;
   logic [7:0] caddr_ff, cwdata_ff, dwdata_ff;
   logic       cwr_ff, crd_ff, dwr_ff;

   // sum check before any programming is started
   wire [6:0] sum   = {1'b0, trig_ff} + {1'b0, thr_ff};
   wire       go    = usr_wr && (usr_addr == HOFS_CTRL) && usr_wdata[0];
   wire       sum_ok = (sum <= UTXDR_SUM_LIMIT);
   wire       idle  = (state_ff == UTXDR_S_IDLE);
   wire       req   = lnk.serial_transmit_transfer_request;
   wire       take  = (state_ff == UTXDR_S_BURST) && src_valid;
   wire       last  = take && (left_ff <= 6'h01);
   wire       cfg_last = (step_ff == CFG_LAST_STEP);

   // unlock sequence, one register write per cycle
   logic [7:0] sa, sd;
   always_comb begin
      sa = OFS_PORTAL8;
      sd = 8'h00;
      unique case (step_ff)
         4'h0: begin sa = OFS_LCR_PORTAL; sd = PORTAL_KEY_EFR; end
         4'h1: begin sa = OFS_PORTAL8; sd = 8'h01 << EFR_ENH_BIT; end
         4'h2: begin sa = OFS_LCR_PORTAL; sd = PORTAL_KEY_FCR; end
         4'h3: begin
            sa = OFS_PORTAL8;
            sd = {2'b00, trig_ff[1:0], 4'h0} | (8'h01 << FCR_DMA_BIT);
         end
         4'h4: begin sa = OFS_SUPP; sd = 8'h01 << SCR_FINE_BIT; end
         4'h5: begin sa = OFS_MODEM; sd = 8'h01 << MCR_TLR_BIT; end
         4'h6: begin sa = OFS_TRIG_SEL; sd = {4'h0, trig_ff[5:2]}; end
         4'h7: begin sa = OFS_MODE3; sd = 8'h01 << MODE_DEFINITION_THREE_THR_BIT; end
         4'h8: begin sa = OFS_TXREQ_LVL; sd = {2'b00, thr_ff}; end
         default: begin sa = OFS_PORTAL8; sd = 8'h00; end
      endcase
   end

   // state sequencing
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         UTXDR_S_IDLE:  if (go && sum_ok) nxt_state = UTXDR_S_CFG;
         UTXDR_S_CFG:   if (cfg_last) nxt_state = UTXDR_S_RUN;
         UTXDR_S_RUN:   if (pend_ff) nxt_state = UTXDR_S_BURST;
         UTXDR_S_BURST: if (last) nxt_state = UTXDR_S_RUN;
         default:       nxt_state = UTXDR_S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= UTXDR_S_IDLE;
         step_ff  <= 4'h0;
         left_ff  <= 6'h00;
         pend_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         step_ff  <= (state_ff == UTXDR_S_CFG) ? step_ff + 4'h1 : 4'h0;
         // a request landing as the burst starts stays pending
         pend_ff  <= req || (pend_ff && !(state_ff == UTXDR_S_RUN));
         if (state_ff == UTXDR_S_RUN) left_ff <= lnk.dma_len;
         else if (take) left_ff <= left_ff - 6'h01;
      end
   end

   // software registers; trigger and threshold only change while idle
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         trig_ff      <= 6'h00;
         thr_ff       <= 6'h00;
         refused_ff   <= 1'b0;
         done_ff      <= 1'b0;
         peek_addr_ff <= REG_RST;
         peek_go_ff   <= 1'b0;
      end else begin
         if (usr_wr && idle && usr_addr == HOFS_TRIG) trig_ff <= usr_wdata[5:0];
         if (usr_wr && idle && usr_addr == HOFS_THR)  thr_ff  <= usr_wdata[5:0];
         if (go && idle) refused_ff <= !sum_ok;
         if (cfg_last) done_ff <= 1'b1;
         if (usr_wr && usr_addr == HOFS_PEEK) peek_addr_ff <= usr_wdata;
         peek_go_ff <= usr_wr && (usr_addr == HOFS_PEEK);
      end
   end

   // link drive, all registered; peek reads requested during programming are dropped
   wire cfg_w = (state_ff == UTXDR_S_CFG);
   wire peek_rd = peek_go_ff && !cfg_w;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         caddr_ff     <= REG_RST;
         cwdata_ff    <= REG_RST;
         cwr_ff       <= 1'b0;
         crd_ff       <= 1'b0;
         dwr_ff       <= 1'b0;
         dwdata_ff    <= REG_RST;
         peek_cap_ff  <= 1'b0;
         peek_data_ff <= REG_RST;
         rdata_ff     <= REG_RST;
      end else begin
         caddr_ff    <= cfg_w ? sa : peek_addr_ff;
         cwdata_ff   <= sd;
         cwr_ff      <= cfg_w;
         crd_ff      <= peek_rd;
         dwr_ff      <= take;
         if (take) dwdata_ff <= src_data;
         peek_cap_ff <= crd_ff;
         if (peek_cap_ff) peek_data_ff <= lnk.cfg_rdata;
         unique case (usr_addr)
            HOFS_CTRL:  rdata_ff <= usr_rd ? {5'h00, refused_ff, done_ff, !idle} : 8'h00;
            HOFS_TRIG:  rdata_ff <= usr_rd ? {2'b00, trig_ff} : 8'h00;
            HOFS_THR:   rdata_ff <= usr_rd ? {2'b00, thr_ff} : 8'h00;
            HOFS_PEEKD: rdata_ff <= usr_rd ? peek_data_ff : 8'h00;
            default:    rdata_ff <= 8'h00;
         endcase
      end
   end

   assign lnk.cfg_addr  = caddr_ff;
   assign lnk.cfg_wdata = cwdata_ff;
   assign lnk.cfg_wr    = cwr_ff;
   assign lnk.cfg_rd    = crd_ff;
   assign lnk.dma_wr    = dwr_ff;
   assign lnk.dma_wdata = dwdata_ff;
   assign src_ready     = (state_ff == UTXDR_S_BURST);
   assign usr_rdata     = rdata_ff;
endmodule

// [utxdr_asserts.sv]
`timescale 1ns/1ps
module utxdr_asserts
   import utxdr_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // configuration access
   input  wire logic [7:0] cfg_addr,
   input  wire logic [7:0] cfg_wdata,
   input  wire logic       cfg_wr,
   input  wire logic       cfg_rd,
   input  wire logic [7:0] cfg_rdata,
   // request and refill
   input  wire logic       serial_transmit_transfer_request,
   input  wire logic [5:0] dma_len,
   input  wire logic       dma_wr,
   input  wire logic [7:0] dma_wdata
);
   default clocking dcb @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic [7:0] prt_ff, efr_ff, fcr_ff, mcr_ff, tlr_ff, scr_ff, md3_ff, thr_ff;
   logic [5:0] len_ff;
   logic [6:0] cnt_ff;
   logic       seen_ff;
   // decode of the write on the wire
   wire logic       req    = serial_transmit_transfer_request;
   wire logic       wr_shr = cfg_wr && cfg_addr == OFS_PORTAL8;
   wire logic       wr_tlr = cfg_wr && cfg_addr == OFS_TRIG_SEL;
   wire logic       wr_thr = cfg_wr && cfg_addr == OFS_TXREQ_LVL;
   wire logic [6:0] sum    = {1'b0, tlr_ff[3:0], fcr_ff[5:4]} + {1'b0, cfg_wdata[5:0]};
   ////////////////////////////////////////////////////////////
   // shadow of what was written, so the order of the unlock steps can be judged
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         {prt_ff, efr_ff, fcr_ff, mcr_ff} <= '0;
         {tlr_ff, scr_ff, md3_ff, thr_ff} <= '0;
      end else if (cfg_wr) begin
         if (cfg_addr == OFS_LCR_PORTAL) prt_ff <= cfg_wdata;
         if (wr_shr && prt_ff == PORTAL_KEY_EFR) efr_ff <= cfg_wdata;
         if (wr_shr && prt_ff != PORTAL_KEY_EFR) fcr_ff <= cfg_wdata;
         if (cfg_addr == OFS_MODEM) mcr_ff <= cfg_wdata;
         if (wr_tlr) tlr_ff <= cfg_wdata;
         if (cfg_addr == OFS_SUPP) scr_ff <= cfg_wdata;
         if (cfg_addr == OFS_MODE3) md3_ff <= cfg_wdata;
         if (wr_thr) thr_ff <= cfg_wdata;
      end
   end
   // bytes pushed since the last request; a burst must end before the next request
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff  <= '0;
         len_ff  <= '0;
         seen_ff <= 1'b0;
      end else if (req) begin
         cnt_ff  <= '0;
         len_ff  <= dma_len;
         seen_ff <= 1'b1;
      end else if (dma_wr) begin
         cnt_ff  <= cnt_ff + 7'h01;
      end
   end
   ////////////////////////////////////////////////////////////
   a_req_single: assert property (req |=> !req)
      else $error("request pulse longer than one cycle");
   a_burst_len: assert property (req && seen_ff |-> cnt_ff == {1'b0, len_ff})
      else $error("burst byte count differs from requested length");
   a_efr_keyed: assert property (wr_shr && cfg_wdata == 8'h10 |-> prt_ff == PORTAL_KEY_EFR)
      else $error("feature register written without portal key");
   a_fcr_select: assert property (wr_shr && cfg_wdata[FCR_DMA_BIT] |-> prt_ff == 8'h00)
      else $error("fifo control written without portal cleared");
   a_mcr_unlock: assert property (cfg_wr && cfg_addr == OFS_MODEM |-> efr_ff[EFR_ENH_BIT])
      else $error("modem control written while locked");
   a_tlr_open: assert property (wr_tlr |-> mcr_ff[MCR_TLR_BIT] && efr_ff[EFR_ENH_BIT])
      else $error("trigger register written while closed");
   a_fine_first: assert property (wr_tlr |-> scr_ff[SCR_FINE_BIT])
      else $error("trigger written before fine granularity");
   a_thr_enable: assert property (wr_thr |-> md3_ff[MODE_DEFINITION_THREE_THR_BIT])
      else $error("threshold written before it was enabled");
   a_sum_limit: assert property (wr_thr |-> sum <= UTXDR_SUM_LIMIT)
      else $error("threshold plus trigger above limit");
   a_len_thr: assert property (req && md3_ff[MODE_DEFINITION_THREE_THR_BIT] |-> dma_len == thr_ff[5:0])
      else $error("burst length differs from threshold");
   c_req: cover property (req);
   c_key: cover property (cfg_wr && cfg_addr == OFS_LCR_PORTAL && cfg_wdata == PORTAL_KEY_EFR);
   c_burst: cover property (dma_wr [*8]);
endmodule

// [utxdr_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
   end \
end
module tb
   import utxdr_pkg::*;
;
   logic        clock, arst_n, usr_wr, usr_rd, src_valid, src_ready, run_a;
   logic        tx_ready_a, tx_valid_a, full_a, irq_a, tx_ready_b, tx_valid_b, full_b, irq_b;
   logic [3:0]  usr_addr;
   logic [7:0]  usr_wdata, usr_rdata, src_data, tx_data_a, tx_data_b, rv, q, pv;
   logic [15:0] wlog[$], wexp[$], pk[$], b2[$];
   logic [7:0]  qa[$], qb[$];
   int          n_fail, num_checks, nreq_a, nreq_b, i;
   int unsigned seed = 6;
   utxdr_if lnk_a();
   utxdr_if lnk_b();
   utxdr_dma utxdr_dma_inst (.clock(clock), .arst_n(arst_n), .lnk(lnk_a), .usr_addr(usr_addr),
      .usr_wdata(usr_wdata), .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_rdata(usr_rdata),
      .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready));
   utxdr_dev utxdr_dev_inst (.clock(clock), .arst_n(arst_n), .lnk(lnk_a), .tx_data(tx_data_a),
      .tx_valid(tx_valid_a), .tx_ready(tx_ready_a), .tx_queue_full(full_a), .irq(irq_a));
   // second port driven by hand, so rules of the controller can be broken on purpose
   utxdr_dev utxdr_dev_inst_2 (.clock(clock), .arst_n(arst_n), .lnk(lnk_b), .tx_data(tx_data_b),
      .tx_valid(tx_valid_b), .tx_ready(tx_ready_b), .tx_queue_full(full_b), .irq(irq_b));
   utxdr_asserts utxdr_asserts_inst (.clock(clock), .arst_n(arst_n),
      .cfg_addr(lnk_a.cfg_addr), .cfg_wdata(lnk_a.cfg_wdata), .cfg_wr(lnk_a.cfg_wr),
      .cfg_rd(lnk_a.cfg_rd), .cfg_rdata(lnk_a.cfg_rdata), .dma_len(lnk_a.dma_len),
      .serial_transmit_transfer_request(lnk_a.serial_transmit_transfer_request),
      .dma_wr(lnk_a.dma_wr), .dma_wdata(lnk_a.dma_wdata));
   ////////////////////////////////////////////////////////////
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one access on the software port (dev 0) or the second port's register bus (dev 1)
   task automatic acc(input bit dev, input bit wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      if (dev) begin
         lnk_b.cfg_addr  <= a;
         lnk_b.cfg_wdata <= d;
         lnk_b.cfg_wr    <= wr;
         lnk_b.cfg_rd    <= !wr;
      end else begin
         usr_addr  <= a[3:0];
         usr_wdata <= d;
         usr_wr    <= wr;
         usr_rd    <= !wr;
      end
      @(posedge clock);
      {lnk_b.cfg_wr, lnk_b.cfg_rd, usr_wr, usr_rd} <= 4'h0;
      @(negedge clock);
      q = dev ? lnk_b.cfg_rdata : usr_rdata;
   endtask
   task automatic rd(input bit dev, input logic [7:0] a, input logic [7:0] e);
      acc(dev, 1'b0, a, 8'h00);
      `CHK("read data", e, q)
   endtask
   // device read through the controller; the wait covers the relayed read
   task automatic peek(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, 1'b1, {4'h0, HOFS_PEEK}, a);
      repeat (4) @(posedge clock);
      rd(1'b0, {4'h0, HOFS_PEEKD}, e);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      stop_test();
   end
   // reference queues follow every byte in and out; requests are counted
   always @(posedge clock) begin
      rv = rnd();
      tx_ready_a <= run_a & rv[3];
      if (lnk_a.cfg_wr) wlog.push_back({lnk_a.cfg_addr, lnk_a.cfg_wdata});
      if (src_valid && src_ready) begin
         qa.push_back(src_data);
         src_data <= rv;
      end
      // the output stage holds one byte beyond the 64 queue entries
      if (lnk_b.dma_wr && qb.size() < UTXDR_DEPTH + 1) qb.push_back(lnk_b.dma_wdata);
      if (tx_valid_a && tx_ready_a) begin
         pv = qa.pop_front();
         `CHK("byte a", pv, tx_data_a)
      end
      if (tx_valid_b && tx_ready_b) begin
         pv = qb.pop_front();
         `CHK("byte b", pv, tx_data_b)
      end
      if (lnk_a.serial_transmit_transfer_request) begin
         `CHK("burst length", nreq_a ? 6'h3e : DEFAULT_BURST, lnk_a.dma_len)
         nreq_a++;
      end
      nreq_b += lnk_b.serial_transmit_transfer_request;
   end
   initial begin
      {arst_n, usr_wr, usr_rd, run_a, tx_ready_a, tx_ready_b, usr_addr} = '0;
      {lnk_b.cfg_wr, lnk_b.cfg_rd, lnk_b.dma_wr, lnk_b.cfg_addr, lnk_b.cfg_wdata} = '0;
      {lnk_b.dma_wdata, usr_wdata, src_data} = '0;
      src_valid = 1'b1;
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      rd(1'b0, {4'h0, HOFS_CTRL}, 8'h00);
      // a sum above 63 is refused before anything reaches the serial port
      acc(1'b0, 1'b1, {4'h0, HOFS_TRIG}, 8'h28);
      acc(1'b0, 1'b1, {4'h0, HOFS_THR}, 8'h1e);
      acc(1'b0, 1'b1, {4'h0, HOFS_CTRL}, 8'h01);
      rd(1'b0, {4'h0, HOFS_CTRL}, 8'h04);
      `CHK("writes while refused", 0, wlog.size())
      // trigger 1 plus threshold 62 sits exactly on the limit
      acc(1'b0, 1'b1, {4'h0, HOFS_TRIG}, 8'h01);
      acc(1'b0, 1'b1, {4'h0, HOFS_THR}, 8'h3e);
      acc(1'b0, 1'b1, {4'h0, HOFS_CTRL}, 8'h01);
      repeat (12) @(posedge clock);
      rd(1'b0, {4'h0, HOFS_CTRL}, 8'h03);
      wexp = '{16'h0cbf, 16'h0810, 16'h0c00, 16'h0818, 16'h4040, 16'h1040, 16'h1c00,
               16'h8004, 16'h843e};
      `CHK("write count", 9, wlog.size())
      foreach (wexp[k]) `CHK("unlock step", wexp[k], wlog[k])
      pk = '{16'h0818, 16'h0c00, 16'h1040, 16'h1c00, 16'h4040, 16'h8004, 16'h843e,
             16'h8804, 16'h8c00, 16'h2000};
      foreach (pk[k]) peek(pk[k][15:8], pk[k][7:0]);
      // random stalls of the serialiser drive several crossings
      run_a <= 1'b1;
      for (i = 0; i < 4000 && nreq_a < 4; i++) @(posedge clock);
      run_a <= 1'b0;
      `CHK("requests", 1'b1, nreq_a >= 4)
      repeat (100) @(posedge clock);
      // the byte waiting in the output stage is not counted as a queue entry
      peek(OFS_LEVEL, 8'(qa.size() - 1));
      `CHK("full a", 1'b0, full_a)
      `CHK("irq a masked", 1'b0, irq_a)
      // trigger 63 with the default burst breaks the sum on purpose
      b2 = '{16'h0cbf, 16'h0810, 16'h0c00, 16'h0838, 16'h4040, 16'h1040, 16'h1c0f};
      foreach (b2[k]) acc(1'b1, 1'b1, b2[k][15:8], b2[k][7:0]);
      rd(1'b1, OFS_STATUS, 8'h04);
      `CHK("irq masked", 1'b0, irq_b)
      acc(1'b1, 1'b1, OFS_MASK, 8'h07);
      `CHK("irq raised", 1'b1, irq_b)
      acc(1'b1, 1'b1, OFS_STATUS, 8'h04);
      `CHK("irq cleared", 1'b0, irq_b)
      for (i = 0; i < 66; i++) begin
         @(posedge clock);
         lnk_b.dma_wr    <= 1'b1;
         lnk_b.dma_wdata <= rnd();
      end
      @(posedge clock);
      lnk_b.dma_wr <= 1'b0;
      repeat (2) @(negedge clock);
      `CHK("full b", 1'b1, full_b)
      rd(1'b1, OFS_LEVEL, 8'h40);
      rd(1'b1, OFS_STATUS, 8'h02);
      acc(1'b1, 1'b1, OFS_STATUS, 8'h02);
      // one byte out while the synchronised full flag still lags
      i = nreq_b;
      @(posedge clock);
      tx_ready_b <= 1'b1;
      @(posedge clock);
      tx_ready_b <= 1'b0;
      repeat (8) @(negedge clock);
      `CHK("surplus request", i, nreq_b)
      `CHK("full after pop", 1'b0, full_b)
      // the suppressed crossing still records itself beside the sync error
      rd(1'b1, OFS_STATUS, 8'h05);
      `CHK("irq sync error", 1'b1, irq_b)
      stop_test();
   end
endmodule
